// ---- logic/ring_node_pkg.sv ----
package ring_node_pkg;
  localparam int unsigned SRAM_AW = 19;
  localparam int unsigned TXF_AW = 12;
  localparam int unsigned SRC_AW = 9;
  localparam logic [12:0] TXF_SMALL = 13'h0200;
  localparam logic [12:0] TXF_LARGE = 13'h1000;
  localparam logic [18:0] MASK_64K = 19'h07fff;
  localparam logic [18:0] MASK_256K = 19'h1ffff;
  localparam logic [18:0] MASK_512K = 19'h3ffff;
  localparam logic [18:0] MASK_1M = 19'h7ffff;
  localparam logic [1:0] MEM_256K = 2'h0;
  localparam logic [1:0] MEM_512K = 2'h1;
  localparam int unsigned ADDR_REG_BIT = 20;
  localparam logic [4:0] REG_NODE_ID = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h02;
  localparam logic [4:0] REG_CONTROL = 5'h04;
  localparam logic [4:0] REG_IRQ_CMD = 5'h06;
  localparam logic [4:0] REG_IRQ_SRC = 5'h08;
  localparam logic [4:0] REG_VEC1 = 5'h0a;
  localparam logic [4:0] REG_VEC2 = 5'h0c;
  localparam logic [4:0] REG_VEC3 = 5'h0e;
  localparam int unsigned ST_HALF = 0;
  localparam int unsigned ST_FULL = 1;
  localparam int unsigned ST_SRC_EMPTY = 2;
  localparam int unsigned ST_REDUNDANT = 3;
  localparam int unsigned ST_REDUCED = 4;
  localparam int unsigned CT_HALF_IE = 0;
  localparam int unsigned CT_VECTORED = 1;
  localparam int unsigned CT_TYPE_IE = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int unsigned CMD_TYPE_LSB = 8;
  localparam int unsigned CMD_BCAST = 10;
  localparam int unsigned SRC_VALID = 15;

  typedef enum logic {KIND_DATA = 1'b0, KIND_IRQ = 1'b1} kind_t;

  typedef struct packed {
    kind_t kind;
    logic copy;
    logic err;
    logic [7:0] origin;
    logic [7:0] dest;
    logic bcast;
    logic [1:0] itype;
    logic [SRAM_AW-1:0] addr;
    logic [1:0] be;
    logic [15:0] data;
  } frame_t;

  typedef struct packed {
    logic [7:0] nodeId;
    logic redundant;
    logic reduced;
    logic [1:0] memSize;
    logic fifoLarge;
  } cfg_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_READ = 2'b01,
    H_ACK = 2'b10
  } host_state_t;
endpackage : ring_node_pkg

// ---- logic/sync_fifo.sv ----
`timescale 1ns/1ps
module sync_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned AW = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic push,
  input wire logic [W-1:0] pushData,
  input wire logic pop,
  output logic [W-1:0] popData,
  output logic [AW:0] count
);
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic doPush, doPop;

  always_comb begin
    doPush = push && (count_q != DEPTH);
    doPop = pop && (count_q != '0);
    wrPtr_d = doPush ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = doPop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge clock) begin
    if (doPush) begin
      mem[wrPtr_q] <= pushData;
    end
  end

  assign popData = mem[rdPtr_q];
  assign count = count_q;
endmodule : sync_fifo

// ---- logic/shared_sram.sv ----
`timescale 1ns/1ps
module shared_sram
  import ring_node_pkg::*;
(
  input wire logic clock,
  input wire logic en,
  input wire logic we,
  input wire logic [1:0] be,
  input wire logic [SRAM_AW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:(1<<SRAM_AW)-1];

  // Byte lanes are written independently so byte stores leave the rest.
  always_ff @(posedge clock) begin
    if (en && we && be[0]) begin
      mem[addr][7:0] <= wdata[7:0];
    end
    if (en && we && be[1]) begin
      mem[addr][15:8] <= wdata[15:8];
    end
    if (en && !we) begin
      rdata <= mem[addr];
    end
  end
endmodule : shared_sram

// ---- logic/ring_shared_memory_node.sv ----
`timescale 1ns/1ps
// Behaviour
// - Forward every error-free received transfer not originated here.
// - Strip own transfers returning around ring.
// - Insert local transfers between passing ones.
// - Launched transfers carry this node's number.
// - Node number from pins, readable by software.
// - Host writes go to SRAM and queue.
// - Ring data written at its original address.
// - Three interrupt types with software vectors.
// - Interrupt to one node or to all.
// - Interrupts follow earlier data in order.
// - Own interrupts push sender into 512-entry FIFO.
// - Host reads sender numbers from that FIFO.
// - Vectored and nonvectored host interrupt signalling.
// - Reduced option limits host SRAM to 64K.
// - SRAM sized 256K, 512K or 1M.
// - Transmit FIFO holds 512 or 4K transfers.
// - Host accesses memory bytewise or wordwise.
// - Replication works from reset without setup.
// - Redundant mode sends twice, keeps good copy.
// - Ring data arbitrated, written to SRAM, queued.
// - Half-full transmit FIFO sets status, interrupts.
// - Full transmit FIFO stalls host writes.
module ring_shared_memory_node
  import ring_node_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [20:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [1:0] byteenable,
  input wire logic [15:0] writedata,
  output logic [15:0] readdata,
  output logic waitrequest,
  input wire logic rxValid,
  input wire frame_t rxFrame,
  output logic rxReady,
  output logic txValid,
  output frame_t txFrame,
  input wire logic txReady,
  input wire logic [7:0] nodeIdPins,
  input wire logic redundantPin,
  input wire logic reducedMemPin,
  input wire logic [1:0] memSizePins,
  input wire logic fifoLargePin,
  output logic hostIrq,
  output logic [7:0] hostVector
);
  function automatic logic [SRAM_AW-1:0] memMask(input logic [1:0] size,
                                                 input logic reduced);
    if (reduced) begin
      return MASK_64K;
    end
    unique case (size)
      MEM_256K: return MASK_256K;
      MEM_512K: return MASK_512K;
      default: return MASK_1M;
    endcase
  endfunction : memMask

  cfg_t cfgMeta_q, cfg_q;
  // Straps are static but still cross into the clock domain by two stages.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfgMeta_q <= '0;
      cfg_q <= '0;
    end else begin
      cfgMeta_q <= {nodeIdPins, redundantPin, reducedMemPin, memSizePins,
                    fifoLargePin};
      cfg_q <= cfgMeta_q;
    end
  end

  frame_t rxHeld_q, rxHeld_d, txFrame_q, txFrame_d;
  frame_t pushFrame, localFrame, headFrame;
  logic rxFull_q, rxFull_d, rxReady_q, rxReady_d, skipCopy_q, skipCopy_d;
  logic own, useIt, fwdNeed, rxDone, fwdPush, ringWrite, srcPush;
  logic txValid_q, txValid_d, txPush, txPop, localPush, txFull, txHalf;
  logic [12:0] txCount, txCap;
  logic [9:0] srcHead;
  logic [9:0] srcCount;
  logic srcEmpty, srcPop;
  logic hostSram, hostWe, sramEn, sramWe;
  logic [SRAM_AW-1:0] hostAddr, sramAddr;
  logic [1:0] sramBe;
  logic [15:0] sramWdata, sramRdata;

  always_comb begin
    txCap = cfg_q.fifoLarge ? TXF_LARGE : TXF_SMALL;
    txFull = txCount >= txCap;
    txHalf = txCount >= (txCap >> 1);
    srcEmpty = srcCount == '0;
  end

  // The ring path needs no register setup, so it runs straight from reset.
  always_comb begin
    own = rxHeld_q.origin == cfg_q.nodeId;
    if (!cfg_q.redundant || !rxHeld_q.copy) begin
      useIt = !rxHeld_q.err;
    end else begin
      useIt = !skipCopy_q && !rxHeld_q.err;
    end
    fwdNeed = useIt && !own;
    rxDone = rxFull_q && !(fwdNeed && txFull);
    fwdPush = rxDone && fwdNeed;
    ringWrite = fwdPush && rxHeld_q.kind == KIND_DATA;
    srcPush = fwdPush && rxHeld_q.kind == KIND_IRQ &&
              (rxHeld_q.bcast || rxHeld_q.dest == cfg_q.nodeId);
    skipCopy_d = skipCopy_q;
    if (rxDone && cfg_q.redundant) begin
      skipCopy_d = !rxHeld_q.copy && !rxHeld_q.err;
    end
    rxHeld_d = rxHeld_q;
    rxFull_d = rxFull_q && !rxDone;
    if (rxValid && rxReady_q) begin
      rxHeld_d = rxFrame;
      rxFull_d = 1'b1;
    end
    rxReady_d = !rxFull_d;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxHeld_q <= '0;
      rxFull_q <= 1'b0;
      rxReady_q <= 1'b0;
      skipCopy_q <= 1'b0;
    end else begin
      rxHeld_q <= rxHeld_d;
      rxFull_q <= rxFull_d;
      rxReady_q <= rxReady_d;
      skipCopy_q <= skipCopy_d;
    end
  end

  // One queue carries both forwarded and local traffic, which keeps an
  // interrupt command behind every data transfer queued before it.
  always_comb begin
    txPush = fwdPush || localPush;
    pushFrame = fwdPush ? rxHeld_q : localFrame;
    pushFrame.copy = 1'b0;
    pushFrame.err = 1'b0;
  end

  sync_fifo #(
    .W($bits(frame_t)),
    .AW(TXF_AW)
  ) txQueue (
    .clock(clock),
    .resetn(resetn),
    .push(txPush),
    .pushData(pushFrame),
    .pop(txPop),
    .popData(headFrame),
    .count(txCount)
  );

  always_comb begin
    txValid_d = txValid_q;
    txFrame_d = txFrame_q;
    txPop = 1'b0;
    if (txValid_q && txReady && cfg_q.redundant && !txFrame_q.copy) begin
      txFrame_d.copy = 1'b1;
    end else if (!txValid_q || txReady) begin
      txValid_d = txCount != '0;
      if (txCount != '0) begin
        txPop = 1'b1;
        txFrame_d = headFrame;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txValid_q <= 1'b0;
      txFrame_q <= '0;
    end else begin
      txValid_q <= txValid_d;
      txFrame_q <= txFrame_d;
    end
  end

  sync_fifo #(
    .W(10),
    .AW(SRC_AW)
  ) srcQueue (
    .clock(clock),
    .resetn(resetn),
    .push(srcPush),
    .pushData({rxHeld_q.itype, rxHeld_q.origin}),
    .pop(srcPop),
    .popData(srcHead),
    .count(srcCount)
  );

  host_state_t state_q, state_d;
  logic wait_q, wait_d;
  logic [15:0] rdata_q, rdata_d, statusWord;
  logic [7:0] ctrl_q, ctrl_d;
  logic [3:1][7:0] vec_q, vec_d;
  logic regHit;
  logic [1:0] cmdType;

  always_comb begin
    hostAddr = address[19:1] & memMask(cfg_q.memSize, cfg_q.reduced);
    regHit = address[19:5] == '0;
    cmdType = writedata[CMD_TYPE_LSB +: 2];
    statusWord = '0;
    statusWord[ST_HALF] = txHalf;
    statusWord[ST_FULL] = txFull;
    statusWord[ST_SRC_EMPTY] = srcEmpty;
    statusWord[ST_REDUNDANT] = cfg_q.redundant;
    statusWord[ST_REDUCED] = cfg_q.reduced;
  end

  always_comb begin
    state_d = state_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    vec_d = vec_q;
    localPush = 1'b0;
    localFrame = '0;
    localFrame.origin = cfg_q.nodeId;
    hostSram = 1'b0;
    hostWe = 1'b0;
    srcPop = 1'b0;
    unique case (state_q)
      H_IDLE: begin
        if ((read || write) && address[ADDR_REG_BIT]) begin
          state_d = H_ACK;
          wait_d = 1'b0;
          rdata_d = '0;
          if (write && regHit && address[4:0] == REG_IRQ_CMD &&
              byteenable[1]) begin
            if (txFull || rxFull_q) begin
              state_d = H_IDLE;
              wait_d = 1'b1;
            end else begin
              localPush = cmdType != 2'h0;
              localFrame.kind = KIND_IRQ;
              localFrame.itype = cmdType;
              localFrame.bcast = writedata[CMD_BCAST];
              localFrame.dest = writedata[7:0];
            end
          end else if (write && regHit && byteenable[0]) begin
            unique case (address[4:0])
              REG_CONTROL: ctrl_d = writedata[7:0];
              REG_VEC1: vec_d[1] = writedata[7:0];
              REG_VEC2: vec_d[2] = writedata[7:0];
              REG_VEC3: vec_d[3] = writedata[7:0];
              default: ctrl_d = ctrl_q;
            endcase
          end else if (read && regHit) begin
            unique case (address[4:0])
              REG_NODE_ID: rdata_d = {8'h00, cfg_q.nodeId};
              REG_STATUS: rdata_d = statusWord;
              REG_CONTROL: rdata_d = {8'h00, ctrl_q};
              REG_IRQ_SRC: begin
                srcPop = !srcEmpty;
                rdata_d = srcEmpty ? 16'h0000 : {1'b1, 5'h00, srcHead};
              end
              REG_VEC1: rdata_d = {8'h00, vec_q[1]};
              REG_VEC2: rdata_d = {8'h00, vec_q[2]};
              REG_VEC3: rdata_d = {8'h00, vec_q[3]};
              default: rdata_d = '0;
            endcase
          end
        end else if ((read || write) && !rxFull_q &&
                     !(write && txFull)) begin
          hostSram = 1'b1;
          hostWe = write;
          localPush = write;
          localFrame.kind = KIND_DATA;
          localFrame.addr = hostAddr;
          localFrame.be = byteenable;
          localFrame.data = writedata;
          state_d = write ? H_ACK : H_READ;
          wait_d = !write;
        end
      end
      H_READ: begin
        rdata_d = sramRdata;
        wait_d = 1'b0;
        state_d = H_ACK;
      end
      H_ACK: state_d = H_IDLE;
      default: state_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= H_IDLE;
      wait_q <= 1'b1;
      rdata_q <= '0;
      ctrl_q <= CONTROL_RESET;
      vec_q <= '0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      vec_q <= vec_d;
    end
  end

  // Ring writes own the SRAM; the host only gets it while the stage is empty.
  always_comb begin
    sramEn = ringWrite || hostSram;
    sramWe = ringWrite || hostWe;
    sramAddr = ringWrite ?
               rxHeld_q.addr & memMask(cfg_q.memSize, 1'b0) : hostAddr;
    sramBe = ringWrite ? rxHeld_q.be : byteenable;
    sramWdata = ringWrite ? rxHeld_q.data : writedata;
  end

  shared_sram sram (
    .clock(clock),
    .en(sramEn),
    .we(sramWe),
    .be(sramBe),
    .addr(sramAddr),
    .wdata(sramWdata),
    .rdata(sramRdata)
  );

  logic irq_q, irq_d, pending;
  logic [7:0] vector_q, vector_d;
  logic [3:1] typeIe;
  logic [1:0] headType;

  always_comb begin
    typeIe = ctrl_q[CT_TYPE_IE +: 3];
    headType = srcHead[9:8];
    pending = !srcEmpty && headType != 2'h0 && typeIe[headType];
    irq_d = pending || (txHalf && ctrl_q[CT_HALF_IE]);
    vector_d = (pending && ctrl_q[CT_VECTORED]) ? vec_q[headType] : 8'h00;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
      vector_q <= '0;
    end else begin
      irq_q <= irq_d;
      vector_q <= vector_d;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign rxReady = rxReady_q;
  assign txValid = txValid_q;
  assign txFrame = txFrame_q;
  assign hostIrq = irq_q;
  assign hostVector = vector_q;

  property p_strip;
    @(posedge clock) disable iff (!resetn)
    rxFull_q && own |-> !fwdPush && !ringWrite && !srcPush;
  endproperty
  a_strip: assert property (p_strip)
    else $error("own transfer not stripped");

  property p_forward;
    @(posedge clock) disable iff (!resetn)
    fwdPush |=> txCount == $past(txCount) + 13'h0001 - {12'h000, $past(txPop)};
  endproperty
  a_forward: assert property (p_forward)
    else $error("forwarded transfer not queued");

  property p_origin;
    @(posedge clock) disable iff (!resetn)
    localPush |-> pushFrame.origin == cfg_q.nodeId && !fwdPush;
  endproperty
  a_origin: assert property (p_origin)
    else $error("local transfer lacks node number");

  property p_ring_write;
    @(posedge clock) disable iff (!resetn)
    ringWrite |-> sramWe && sramEn &&
      sramAddr == (rxHeld_q.addr & memMask(cfg_q.memSize, 1'b0));
  endproperty
  a_ring_write: assert property (p_ring_write)
    else $error("ring data not written at its address");

  property p_full_stall;
    @(posedge clock) disable iff (!resetn)
    state_q == H_IDLE && write && !address[ADDR_REG_BIT] && txFull
      |=> waitrequest;
  endproperty
  a_full_stall: assert property (p_full_stall)
    else $error("host write acked while queue full");

  property p_twice;
    @(posedge clock) disable iff (!resetn)
    txValid && txReady && cfg_q.redundant && !txFrame.copy
      |=> txValid && txFrame.copy && txFrame.addr == $past(txFrame.addr);
  endproperty
  a_twice: assert property (p_twice)
    else $error("redundant copy not sent");

  property p_reduced;
    @(posedge clock) disable iff (!resetn)
    hostSram && cfg_q.reduced |-> sramAddr[18:15] == 4'h0;
  endproperty
  a_reduced: assert property (p_reduced)
    else $error("host access outside 64K window");

  property p_reg_ack;
    @(posedge clock) disable iff (!resetn)
    state_q == H_IDLE && read && address[ADDR_REG_BIT]
      |=> !waitrequest ##1 waitrequest;
  endproperty
  a_reg_ack: assert property (p_reg_ack)
    else $error("register read not answered in one cycle");

  property p_half_irq;
    @(posedge clock) disable iff (!resetn)
    txHalf && ctrl_q[CT_HALF_IE] |=> hostIrq;
  endproperty
  a_half_irq: assert property (p_half_irq)
    else $error("half full interrupt missing");

  property p_src_pop;
    @(posedge clock) disable iff (!resetn)
    srcPop && !srcPush |=> srcCount == $past(srcCount) - 10'h001;
  endproperty
  a_src_pop: assert property (p_src_pop)
    else $error("source read did not pop");

  c_fwd: cover property (@(posedge clock) disable iff (!resetn) fwdPush);
  c_strip: cover property (@(posedge clock) disable iff (!resetn)
    rxFull_q && own);
  c_src: cover property (@(posedge clock) disable iff (!resetn) srcPush);
  c_stall: cover property (@(posedge clock) disable iff (!resetn)
    write && txFull && waitrequest);
endmodule : ring_shared_memory_node

// ---- verif/ring_neighbour_model.sv ----
`timescale 1ns/1ps
module ring_neighbour_model
  import ring_node_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  output logic rxValid,
  output frame_t rxFrame,
  input wire logic rxReady,
  input wire logic txValid,
  input wire frame_t txFrame,
  output logic txReady
);
  frame_t got[$];
  int stuck = 0;
  logic hold = 1'b0;
  logic [1:0] phase = 2'h0;

  initial begin
    rxValid = 1'b0;
    rxFrame = '0;
    txReady = 1'b0;
  end

  // The downstream node stalls one cycle in four, and fully while hold is set.
  always @(posedge clock) begin
    if (txValid && txReady) begin
      got.push_back(txFrame);
    end
    phase <= phase + 2'h1;
    txReady <= resetn && !hold && (phase != 2'h3);
  end

  // The upstream node holds a frame until taken, then shows its inverse.
  task automatic send(input frame_t f);
    int n;
    n = 0;
    @(posedge clock);
    rxFrame <= f;
    rxValid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (rxReady !== 1'b1 && n < 100);
    if (rxReady !== 1'b1) stuck++;
    rxValid <= 1'b0;
    rxFrame <= ~f;
  endtask : send
endmodule : ring_neighbour_model

// ---- verif/test_ring_shared_memory_node.sv ----
`timescale 1ns/1ps
module test_ring_shared_memory_node import ring_node_pkg::*;;
  localparam logic [7:0] ME = 8'h2a;
  logic clock, resetn, read, write, waitrequest, rxValid, rxReady;
  logic txValid, txReady, redundantPin, reducedMemPin, fifoLargePin;
  logic hostIrq;
  logic [20:0] address;
  logic [1:0] byteenable, memSizePins;
  logic [15:0] writedata, readdata;
  logic [7:0] nodeIdPins, hostVector;
  frame_t rxFrame, txFrame;
  int n_mismatch = 0;
  int comparisons = 0;
  int lastWait = 0;

  ring_shared_memory_node i_ring_shared_memory_node (.clock, .resetn,
    .address, .read, .write, .byteenable, .writedata, .readdata,
    .waitrequest, .rxValid, .rxFrame, .rxReady, .txValid, .txFrame,
    .txReady, .nodeIdPins, .redundantPin, .reducedMemPin, .memSizePins,
    .fifoLargePin, .hostIrq, .hostVector);
  ring_neighbour_model i_ring_neighbour_model (.clock, .resetn, .rxValid,
    .rxFrame, .rxReady, .txValid, .txFrame, .txReady);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [20:0] ra(logic [4:0] o);
    return {1'b1, 15'h0, o};
  endfunction : ra

  function automatic logic [20:0] wa(logic [18:0] w);
    return {1'b0, w, 1'b0};
  endfunction : wa

  function automatic frame_t mk(kind_t k, logic [7:0] o, logic [7:0] d,
      logic b, logic [1:0] t, logic [18:0] a, logic [15:0] v, logic [1:0] e);
    frame_t f;
    f = '0;
    f.kind = k;
    f.origin = o;
    f.dest = d;
    f.bcast = b;
    f.itype = t;
    f.addr = a;
    f.data = v;
    f.be = e;
    return f;
  endfunction : mk

  task automatic bus_op(input logic wr, input logic [20:0] a,
      input logic [1:0] be, input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    byteenable <= be;
    writedata <= d;
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 2000);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    lastWait = n;
    if (n >= 2000) check("bus answer", 0, 1);
  endtask : bus_op

  task automatic bwr(input logic [20:0] a, input logic [1:0] be,
                     input logic [15:0] d);
    logic [15:0] q;
    bus_op(1'b1, a, be, d, q);
  endtask : bwr

  task automatic brd(input logic [20:0] a, output logic [15:0] q);
    bus_op(1'b0, a, 2'h3, 16'h0, q);
  endtask : brd

  task automatic expect_tx(input frame_t e);
    frame_t f;
    int n;
    n = 0;
    while (i_ring_neighbour_model.got.size() == 0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    f = (n < 300) ? i_ring_neighbour_model.got.pop_front() : ~e;
    if (e.kind == KIND_DATA)
      check("data frame", {f.kind, f.copy, f.err, f.origin, f.addr, f.be,
        f.data}, {e.kind, e.copy, e.err, e.origin, e.addr, e.be, e.data});
    else
      check("irq frame", {f.kind, f.copy, f.err, f.origin, f.dest, f.bcast,
        f.itype}, {e.kind, e.copy, e.err, e.origin, e.dest, e.bcast, e.itype});
  endtask : expect_tx

  task automatic flush(input int cycles);
    repeat (cycles) @(posedge clock);
    i_ring_neighbour_model.got.delete();
  endtask : flush

  task automatic t_regs;
    logic [15:0] q;
    brd(ra(REG_NODE_ID), q);
    check("node id", q[7:0], ME);
    nodeIdPins <= 8'hff;
    repeat (3) @(posedge clock);
    brd(ra(REG_NODE_ID), q);
    check("node id max", q[7:0], 8'hff);
    nodeIdPins <= ME;
    repeat (3) @(posedge clock);
    brd(ra(REG_CONTROL), q);
    check("control reset", q[7:0], CONTROL_RESET);
    brd(ra(REG_STATUS), q);
    check("source empty", q[ST_SRC_EMPTY], 1'b1);
    brd(ra(5'h1e), q);
    check("unmapped", q, 16'h0000);
  endtask : t_regs

  task automatic t_host_write;
    logic [15:0] q;
    bwr(wa(19'h00020), 2'h3, 16'ha5c3);
    bwr(wa(19'h00020), 2'h2, 16'h7e00);
    brd(wa(19'h00020), q);
    check("byte lane", q, 16'h7ec3);
    expect_tx(mk(KIND_DATA, ME, 0, 0, 0, 19'h20, 16'ha5c3, 2'h3));
    expect_tx(mk(KIND_DATA, ME, 0, 0, 0, 19'h20, 16'h7e00, 2'h2));
  endtask : t_host_write

  task automatic t_forward;
    logic [15:0] q;
    frame_t f;
    f = mk(KIND_DATA, 8'h07, 0, 0, 0, 19'h4567b, 16'hbeef, 2'h3);
    i_ring_neighbour_model.send(f);
    expect_tx(f);
    brd(wa(19'h4567b), q);
    check("ring data", q, 16'hbeef);
    f = mk(KIND_DATA, ME, 0, 0, 0, 19'h00100, 16'h1111, 2'h3);
    i_ring_neighbour_model.send(f);
    repeat (30) @(posedge clock);
    check("stripped", i_ring_neighbour_model.got.size(), 0);
  endtask : t_forward

  task automatic t_irq_launch;
    bwr(wa(19'h00010), 2'h3, 16'h1234);
    bwr(ra(REG_IRQ_CMD), 2'h3, 16'h0244);
    expect_tx(mk(KIND_DATA, ME, 0, 0, 0, 19'h10, 16'h1234, 2'h3));
    expect_tx(mk(KIND_IRQ, ME, 8'h44, 0, 2'h2, 0, 0, 0));
    bwr(ra(REG_IRQ_CMD), 2'h3, 16'h0044);
    for (int t = 1; t < 4; t++) begin
      bwr(ra(REG_IRQ_CMD), 2'h3, {5'h0, 1'b1, 2'(t), 8'h99});
      expect_tx(mk(KIND_IRQ, ME, 8'h99, 1, 2'(t), 0, 0, 0));
    end
  endtask : t_irq_launch

  task automatic t_irq_receive;
    logic [15:0] q;
    bwr(ra(REG_VEC1), 2'h3, 16'h005c);
    bwr(ra(REG_VEC3), 2'h3, 16'h00c7);
    bwr(ra(REG_CONTROL), 2'h3, 16'h0052);
    i_ring_neighbour_model.send(mk(KIND_IRQ, 8'h33, ME, 0, 2'h1, 0, 0, 0));
    i_ring_neighbour_model.send(mk(KIND_IRQ, 8'h61, 8'h05, 1, 2'h3, 0, 0, 0));
    i_ring_neighbour_model.send(mk(KIND_IRQ, 8'h62, 8'h05, 0, 2'h1, 0, 0, 0));
    repeat (4) @(posedge clock);
    check("irq line", hostIrq, 1'b1);
    check("vector 1", hostVector, 8'h5c);
    brd(ra(REG_IRQ_SRC), q);
    check("source 1", q, 16'h8133);
    repeat (3) @(posedge clock);
    check("vector 3", hostVector, 8'hc7);
    bwr(ra(REG_CONTROL), 2'h3, 16'h0050);
    repeat (3) @(posedge clock);
    check("nonvectored", {hostIrq, hostVector}, 9'h100);
    brd(ra(REG_IRQ_SRC), q);
    check("source 2", q, 16'h8361);
    brd(ra(REG_IRQ_SRC), q);
    check("source none", q, 16'h0000);
    brd(ra(REG_STATUS), q);
    check("source drained", q[ST_SRC_EMPTY], 1'b1);
    check("irq idle", hostIrq, 1'b0);
    flush(20);
  endtask : t_irq_receive

  task automatic t_reduced;
    logic [15:0] q;
    reducedMemPin <= 1'b1;
    repeat (3) @(posedge clock);
    bwr(wa(19'h18005), 2'h3, 16'h0f0f);
    brd(wa(19'h00005), q);
    check("window alias", q, 16'h0f0f);
    brd(ra(REG_STATUS), q);
    check("reduced flag", q[ST_REDUCED], 1'b1);
    reducedMemPin <= 1'b0;
    flush(20);
  endtask : t_reduced

  task automatic t_redundant;
    frame_t f, g;
    redundantPin <= 1'b1;
    repeat (3) @(posedge clock);
    f = mk(KIND_DATA, 8'h07, 0, 0, 0, 19'h00400, 16'h1357, 2'h3);
    g = f;
    g.copy = 1'b1;
    g.data = 16'h2468;
    i_ring_neighbour_model.send(f);
    i_ring_neighbour_model.send(g);
    g.data = 16'h1357;
    expect_tx(f);
    expect_tx(g);
    f.err = 1'b1;
    g.data = 16'h5555;
    i_ring_neighbour_model.send(f);
    i_ring_neighbour_model.send(g);
    f.err = 1'b0;
    f.data = 16'h5555;
    expect_tx(f);
    expect_tx(g);
    redundantPin <= 1'b0;
    flush(20);
  endtask : t_redundant

  task automatic t_fill;
    logic [15:0] q;
    bwr(ra(REG_CONTROL), 2'h3, 16'h0001);
    i_ring_neighbour_model.hold <= 1'b1;
    repeat (250) bwr(wa(19'h00200), 2'h3, 16'h0001);
    brd(ra(REG_STATUS), q);
    check("below half", q[ST_HALF], 1'b0);
    repeat (7) bwr(wa(19'h00200), 2'h3, 16'h0002);
    brd(ra(REG_STATUS), q);
    check("half flag", q[ST_HALF], 1'b1);
    check("half irq", hostIrq, 1'b1);
    repeat (256) bwr(wa(19'h00200), 2'h3, 16'h0003);
    brd(ra(REG_STATUS), q);
    check("full flag", q[ST_FULL], 1'b1);
    fork
      bwr(wa(19'h00300), 2'h3, 16'h5a5a);
      begin
        repeat (40) @(posedge clock);
        i_ring_neighbour_model.hold <= 1'b0;
      end
    join
    check("write stalled", lastWait > 40, 1'b1);
    repeat (1000) @(posedge clock);
    check("none lost", i_ring_neighbour_model.got.size(), 514);
    brd(wa(19'h00300), q);
    check("stalled write", q, 16'h5a5a);
  endtask : t_fill

  initial begin
    resetn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    byteenable = '0;
    writedata = '0;
    nodeIdPins = ME;
    redundantPin = 1'b0;
    reducedMemPin = 1'b0;
    memSizePins = 2'h2;
    fifoLargePin = 1'b0;
    repeat (2) @(posedge clock);
    check("reset wait", waitrequest, 1'b1);
    check("reset tx", txValid, 1'b0);
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    t_host_write();
    t_regs();
    t_forward();
    t_irq_launch();
    t_irq_receive();
    t_reduced();
    t_redundant();
    t_fill();
    check("rx stuck", i_ring_neighbour_model.stuck, 0);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : test_ring_shared_memory_node
